/* File: common/sscl_pkg.sv */
package sscl_pkg;
	// line indices (byte address not used: the store is word addressed)
	localparam logic [0:0]  line_one_idx      = 1'h0;
	localparam logic [0:0]  line_two_idx      = 1'h1;
	localparam int          data_w            = 16;
	localparam int          ecc_w             = 6;
	// defaults: line one 0110_0000_0000_0000, line two k=0111, edge inverted, dir off
	localparam logic [15:0] line_one_rst      = 16'h6000;
	localparam logic [15:0] line_two_rst      = 16'h7424;
	// line one field positions
	localparam int          uncal_adapt_pos   = 15;
	localparam int          stop_en_pos       = 14;
	localparam int          high_speed_pos    = 13;
	localparam int          dir_change_pos    = 12;
	localparam int          sys_guard_en_pos  = 11;
	localparam int          delay_lsb         = 9;
	localparam int          pulse_width_lsb   = 6;
	localparam int          stand_tmo_pos     = 5;
	localparam int          time_guard_pos    = 4;
	localparam int          first_edge_pos    = 3;
	localparam int          hybrid_inh_pos    = 2;
	localparam int          stand_en_pos      = 1;
	localparam int          bias_mode_pos     = 0;
	// line two field position, then alt crank code, clock, timing and guard constants
	localparam int          k_factor_lsb      = 12;
	localparam logic [2:0]  pw_alt_crank      = 3'h6;
	localparam int          clk_ns            = 100;
	localparam int          delay_base_us     = 14;
	localparam int          delay_step_us     = 3;
	localparam int          stand_short_ms    = 40;
	localparam int          stand_long_ms     = 80;
	localparam int          time_guard_ms     = 1400;
	localparam int          guard_limit       = 8;
	localparam logic [3:0]  guard_limit_v     = 4'h8;
	// ratio in 1/64 units: 39.1% is 25/64, step 1/64
	localparam logic [6:0]  k_base            = 7'h19;
endpackage

/* File: rtl/sscl_config_lines.sv */
`timescale 1ns/1ps
module sscl_config_lines #(
	parameter int time_guard_cycles = sscl_pkg::time_guard_ms * 10000
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wr_en,
	input  wire logic        addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        rd_en,
	input  wire logic [5:0]  ecc_flip,
	input  wire logic        guard_extreme_seq,
	input  wire logic        out_switch,
	input  wire logic [11:0] sig_min,
	input  wire logic [11:0] sig_max,
	output logic      [15:0] rd_data,
	output logic             ecc_corrected,
	output logic             uncal_adapt_sel,
	output logic             stop_mode_en,
	output logic             high_speed_hold,
	output logic             dir_change_eighth,
	output logic [7:0]       delay_cycles,
	output logic [12:0]      fwd_pulse_cycles,
	output logic [12:0]      rev_pulse_cycles,
	output logic [12:0]      stand_pulse_cycles,
	output logic             stand_pulse_en,
	output logic [19:0]      stand_wait_cycles,
	output logic             first_edge_policy,
	output logic             first_edge_silent,
	output logic             calib_hold,
	output logic             hybrid_inhibit,
	output logic             bias_zero,
	output logic             offset_reset,
	output logic [11:0]      switch_threshold
);
	localparam int us_cyc = 1000 / sscl_pkg::clk_ns;
	localparam int ms_cyc = 1000 * us_cyc;
	logic [21:0] line [2];
	logic [21:0] next_line [2];
	logic [15:0] fix [2];
	logic [1:0]  fixed;
	logic [15:0] l0, l1;
	logic [15:0] next_rd_data;
	logic        next_ecc_corrected;

	// hamming over 21 positions: data skips the powers of two, so no data bit
	// shares a syndrome with a check bit; bit 5 is parity over the whole word
	function automatic logic [4:0] ecc_pos(input int i);
		return 5'(i + 3 + int'(i >= 1) + int'(i >= 4) + int'(i >= 11));
	endfunction

	function automatic logic [5:0] ecc_gen(input logic [15:0] d);
		logic [5:0] p;
		logic [4:0] q;
		p = '0;
		for (int i = 0; i < 16; i++) begin
			q = ecc_pos(i);
			for (int b = 0; b < 5; b++) begin
				if (q[b]) p[b] = p[b] ^ d[i];
			end
		end
		p[5] = ^{d, p[4:0]};
		return p;
	endfunction

	// single-bit data error is flipped back; check-bit errors leave data intact;
	// a double error keeps overall parity even, so it is only flagged
	function automatic logic [16:0] ecc_fix(input logic [21:0] w);
		logic [5:0]  g;
		logic [5:0]  s;
		logic [15:0] d;
		g = ecc_gen(w[15:0]);
		s = {^w, g[4:0] ^ w[20:16]};
		d = w[15:0];
		for (int i = 0; i < 16; i++) begin
			if (s[5] && s[4:0] == ecc_pos(i)) d[i] = ~d[i];
		end
		return {s != 6'h0, d};
	endfunction

	for (genvar g = 0; g < 2; g++) begin : g_fix
		assign {fixed[g], fix[g]} = ecc_fix(line[g]);
	end
	assign l0 = fix[0];
	assign l1 = fix[1];

	always_comb begin
		next_line = line;
		next_rd_data = rd_data;
		next_ecc_corrected = 1'b0;
		if (wr_en) begin
			// whole-word write regenerates the check bits
			next_line[addr] = {ecc_gen(wr_data), wr_data};
		end else if (|ecc_flip) begin
			next_line[addr] = line[addr] ^ {ecc_flip, 16'h0};
		end
		if (rd_en) begin
			next_rd_data = fix[addr];
			next_ecc_corrected = fixed[addr];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			line[0] <= {ecc_gen(sscl_pkg::line_one_rst), sscl_pkg::line_one_rst};
			line[1] <= {ecc_gen(sscl_pkg::line_two_rst), sscl_pkg::line_two_rst};
			rd_data <= 16'h0;
			ecc_corrected <= 1'b0;
		end else begin
			line <= next_line;
			rd_data <= next_rd_data;
			ecc_corrected <= next_ecc_corrected;
		end
	end

	// field decode
	logic [2:0]  pw;
	logic        alt;
	logic [12:0] n_fwd, n_rev, n_std;
	logic [7:0]  n_dly;
	logic [3:0]  gcnt, next_gcnt;
	logic [24:0] tcnt, next_tcnt;
	logic        next_hold, next_oreset;
	logic [18:0] prod;
	logic [11:0] n_thr;
	assign pw  = l0[sscl_pkg::pulse_width_lsb +: 3];
	assign alt = (pw == sscl_pkg::pw_alt_crank);

	always_comb begin
		case (pw)
		3'h0: begin n_fwd = 13'd45; n_rev = 13'd90;  n_std = 13'd180; end
		3'h1: begin n_fwd = 13'd45; n_rev = 13'd180; n_std = 13'd360; end
		3'h2: begin n_fwd = 13'd45; n_rev = 13'd135; n_std = 13'd180; end
		3'h3: begin n_fwd = 13'd75; n_rev = 13'd600; n_std = 13'd360; end
		3'h4: begin n_fwd = 13'd22; n_rev = 13'd45;  n_std = 13'd90;  end
		3'h5: begin n_fwd = 13'd60; n_rev = 13'd120; n_std = 13'd360; end
		3'h6: begin n_fwd = 13'd30; n_rev = 13'd60;  n_std = 13'd0;   end
		default: begin n_fwd = 13'd90; n_rev = 13'd135; n_std = 13'd360; end
		endcase
		n_fwd = 13'(n_fwd * us_cyc);
		n_rev = 13'(n_rev * us_cyc);
		n_std = 13'(n_std * us_cyc);
		n_dly = 8'((sscl_pkg::delay_base_us
			+ sscl_pkg::delay_step_us * int'(l0[sscl_pkg::delay_lsb +: 2])) * us_cyc);
		// guard: count silent extreme sequences, switch clears, limit resets offset
		next_gcnt = gcnt;
		next_oreset = 1'b0;
		if (!l0[sscl_pkg::sys_guard_en_pos] || out_switch) begin
			next_gcnt = 4'h0;
		end else if (guard_extreme_seq) begin
			if (gcnt + 4'h1 >= sscl_pkg::guard_limit_v) begin
				next_gcnt = 4'h0;
				next_oreset = 1'b1;
			end else begin
				next_gcnt = gcnt + 4'h1;
			end
		end
		// power-on calibration timeout
		next_tcnt = tcnt;
		next_hold = 1'b0;
		if (l0[sscl_pkg::time_guard_pos] && tcnt < 25'(time_guard_cycles)) begin
			next_tcnt = tcnt + 25'h1;
			next_hold = 1'b1;
		end
		// threshold = min + span * (25 + k) / 64
		// widen both factors first, a self-sized product would keep only twelve bits
		prod = 19'(sig_max - sig_min) * 19'(sscl_pkg::k_base + 7'(l1[sscl_pkg::k_factor_lsb +: 4]));
		n_thr = sig_min + prod[17:6];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			gcnt <= 4'h0;
			tcnt <= 25'h0;
			calib_hold <= 1'b0;
			offset_reset <= 1'b0;
			{uncal_adapt_sel, stop_mode_en, high_speed_hold, dir_change_eighth} <= 4'h0;
			{stand_pulse_en, first_edge_policy, first_edge_silent} <= 3'h0;
			{hybrid_inhibit, bias_zero} <= 2'h0;
			delay_cycles <= 8'h0;
			fwd_pulse_cycles <= 13'h0;
			rev_pulse_cycles <= 13'h0;
			stand_pulse_cycles <= 13'h0;
			stand_wait_cycles <= 20'h0;
			switch_threshold <= 12'h0;
		end else begin
			gcnt <= next_gcnt;
			tcnt <= next_tcnt;
			calib_hold <= next_hold;
			offset_reset <= next_oreset;
			uncal_adapt_sel <= l0[sscl_pkg::uncal_adapt_pos];
			stop_mode_en <= l0[sscl_pkg::stop_en_pos];
			high_speed_hold <= l0[sscl_pkg::high_speed_pos];
			dir_change_eighth <= l0[sscl_pkg::dir_change_pos];
			delay_cycles <= n_dly;
			fwd_pulse_cycles <= n_fwd;
			rev_pulse_cycles <= n_rev;
			stand_pulse_cycles <= n_std;
			stand_pulse_en <= l0[sscl_pkg::stand_en_pos] && !alt;
			stand_wait_cycles <= l0[sscl_pkg::stand_tmo_pos] ? 20'(sscl_pkg::stand_long_ms * ms_cyc)
				: 20'(sscl_pkg::stand_short_ms * ms_cyc);
			first_edge_policy <= alt && l0[sscl_pkg::first_edge_pos];
			first_edge_silent <= alt && !l0[sscl_pkg::first_edge_pos];
			hybrid_inhibit <= l0[sscl_pkg::hybrid_inh_pos];
			bias_zero <= l0[sscl_pkg::bias_mode_pos];
			switch_threshold <= n_thr;
		end
	end

	stop_mode_a: assert property (@(posedge clock) disable iff (rst)
		stop_mode_en == $past(l0[14]) || $past(rst)) else $error("stop mode mismatch");
	alt_pulse_a: assert property (@(posedge clock) disable iff (rst)
		$past(alt) && !$past(rst) |-> fwd_pulse_cycles == 13'd300 && !stand_pulse_en)
		else $error("alt crank pulse wrong");
	write_read_a: assert property (@(posedge clock) disable iff (rst)
		wr_en && !rd_en ##1 rd_en && !wr_en && addr == $past(addr) |=> rd_data == $past(wr_data, 2))
		else $error("write not read back");
	guard_clear_a: assert property (@(posedge clock) disable iff (rst)
		out_switch |=> gcnt == 4'h0 && !offset_reset) else $error("guard not cleared");
	delay_code_a: assert property (@(posedge clock) disable iff (rst)
		!$past(rst) |-> delay_cycles == 8'(140 + 30 * $past(l0[10:9])))
		else $error("delay count wrong");
	wait_time_a: assert property (@(posedge clock) disable iff (rst)
		!$past(rst) |-> stand_wait_cycles == ($past(l0[5]) ? 20'd800000 : 20'd400000))
		else $error("standstill wait wrong");
	first_edge_a: assert property (@(posedge clock) disable iff (rst)
		!(first_edge_policy && first_edge_silent)) else $error("edge policy clash");
	hold_off_a: assert property (@(posedge clock) disable iff (rst)
		!$past(l0[4]) && !$past(rst) |-> !calib_hold) else $error("hold without enable");
endmodule

/* File: test/sscl_prog_model.sv */
`timescale 1ns/1ps
module sscl_prog_model (
	input  wire logic        clock,
	output logic             wr_en,
	output logic             addr,
	output logic [15:0]      wr_data,
	output logic             rd_en,
	output logic [5:0]       ecc_flip
);
	initial begin
		wr_en = 1'h0;
		addr = 1'h0;
		wr_data = 16'h0000;
		rd_en = 1'h0;
		ecc_flip = 6'h00;
	end
	task automatic write_line(input logic a, input logic [15:0] d);
		@(posedge clock);
		wr_en <= 1'h1;
		addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_en <= 1'h0;
		wr_data <= ~d; // released bus never shows the old word
	endtask
	task automatic write_read(input logic a, input logic [15:0] d);
		@(posedge clock);
		wr_en <= 1'h1;
		addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_en <= 1'h0;
		rd_en <= 1'h1;
		wr_data <= ~d;
		@(posedge clock);
		rd_en <= 1'h0;
	endtask
	task automatic read_line(input logic a);
		@(posedge clock);
		rd_en <= 1'h1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'h0;
	endtask
	task automatic flip(input logic a, input logic [5:0] f);
		@(posedge clock);
		ecc_flip <= f;
		addr <= a;
		@(posedge clock);
		ecc_flip <= 6'h00;
	endtask
endmodule

/* File: test/test_sscl_config_lines.sv */
`timescale 1ns/1ps
module test_sscl_config_lines;
	logic        clock, rst, wr_en, addr, rd_en, guard_extreme_seq, out_switch;
	logic [15:0] wr_data, rd_data;
	logic [5:0]  ecc_flip;
	logic [11:0] sig_min, sig_max, switch_threshold;
	logic        ecc_corrected, uncal_adapt_sel, stop_mode_en, high_speed_hold;
	logic        dir_change_eighth, stand_pulse_en, first_edge_policy, first_edge_silent;
	logic        calib_hold, hybrid_inhibit, bias_zero, offset_reset;
	logic [7:0]  delay_cycles;
	logic [12:0] fwd_pulse_cycles, rev_pulse_cycles, stand_pulse_cycles;
	logic [19:0] stand_wait_cycles;
	int          err_count = 0;
	int          checked = 0;
	int          resets = 0;
	sscl_config_lines #(.time_guard_cycles(50)) u_sscl_config_lines (.clock, .rst, .wr_en,
		.addr, .wr_data, .rd_en, .ecc_flip, .guard_extreme_seq, .out_switch, .sig_min,
		.sig_max, .rd_data, .ecc_corrected, .uncal_adapt_sel, .stop_mode_en,
		.high_speed_hold, .dir_change_eighth, .delay_cycles, .fwd_pulse_cycles,
		.rev_pulse_cycles, .stand_pulse_cycles, .stand_pulse_en, .stand_wait_cycles,
		.first_edge_policy, .first_edge_silent, .calib_hold, .hybrid_inhibit, .bias_zero,
		.offset_reset, .switch_threshold);
	sscl_prog_model u_prog (.clock, .wr_en, .addr, .wr_data, .rd_en, .ecc_flip);
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) if (offset_reset === 1'h1) resets <= resets + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic a, input logic [15:0] d);
		u_prog.write_line(a, d);
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic rd(input logic a, input logic [15:0] exp, input logic cor);
		u_prog.read_line(a);
		// the correction flag stands for one cycle only, so look right after the answer edge
		#1;
		chk(rd_data, exp);
		chk(ecc_corrected, cor);
	endtask
	task automatic t_defaults;
		rd(1'h0, 16'h6000, 1'h0);
		rd(1'h1, 16'h7424, 1'h0);
		chk({uncal_adapt_sel, stop_mode_en, high_speed_hold, dir_change_eighth}, 4'h6);
		u_prog.write_read(1'h1, 16'h5a5a);
		#1;
		chk(rd_data, 16'h5a5a);
	endtask
	task automatic t_pulse;
		int fw[8] = '{45, 45, 45, 75, 22, 60, 30, 90};
		int rv[8] = '{90, 180, 135, 600, 45, 120, 60, 135};
		int ss[8] = '{180, 360, 180, 360, 90, 360, 0, 360};
		for (int c = 0; c < 8; c++) begin
			wr(1'h0, {5'h00, c[1:0], c[2:0], 6'h0a});
			chk(fwd_pulse_cycles, fw[c] * 10);
			chk(rev_pulse_cycles, rv[c] * 10);
			chk(stand_pulse_cycles, ss[c] * 10);
			chk(stand_pulse_en, c != 6);
			chk({first_edge_policy, first_edge_silent}, {c == 6, 1'h0});
			chk(delay_cycles, (14 + 3 * c[1:0]) * 10);
			chk(stand_wait_cycles, 400000);
		end
		wr(1'h0, 16'h0180);
		chk({first_edge_policy, first_edge_silent}, 2'h1);
	endtask
	task automatic t_bits;
		wr(1'h0, 16'hb025);
		chk({uncal_adapt_sel, stop_mode_en, high_speed_hold, dir_change_eighth}, 4'hb);
		chk(stand_wait_cycles, 800000);
		chk({hybrid_inhibit, bias_zero, stand_pulse_en}, 3'h6);
		u_prog.flip(1'h0, 6'h04);
		rd(1'h0, 16'hb025, 1'h1);
		wr(1'h0, 16'h0010);
		chk(calib_hold, 1'h1);
		repeat (60) @(posedge clock);
		#1;
		chk(calib_hold, 1'h0);
	endtask
	task automatic seq(input int n);
		repeat (n) begin
			@(posedge clock);
			guard_extreme_seq <= 1'h1;
			@(posedge clock);
			guard_extreme_seq <= 1'h0;
		end
		repeat (3) @(posedge clock);
	endtask
	task automatic t_guard;
		wr(1'h0, 16'h0800);
		seq(5);
		out_switch <= 1'h1;
		@(posedge clock);
		out_switch <= 1'h0;
		seq(7);
		chk(resets, 0);
		seq(1);
		chk(resets, 1);
	endtask
	task automatic t_thresh;
		sig_min <= 12'h064;
		sig_max <= 12'h0a4;
		wr(1'h1, 16'h7424);
		chk(switch_threshold, 12'h084);
		wr(1'h1, 16'hf424);
		chk(switch_threshold, 12'h08c);
	endtask
	initial begin
		rst = 1'h1;
		guard_extreme_seq = 1'h0;
		out_switch = 1'h0;
		sig_min = 12'h000;
		sig_max = 12'h000;
		repeat (6) @(posedge clock);
		rst <= 1'h0;
		repeat (2) @(posedge clock);
		t_defaults();
		t_pulse();
		t_bits();
		t_guard();
		t_thresh();
		final_report();
	end
	initial begin
		#2000000;
		err_count++;
		final_report();
	end
endmodule
